// [src/fsp_addr_match.sv]
// Purpose: Address recognition for multiprocessor reception
// Assumes: Inputs are stable registered values
// Notes: Either a masked match or a broadcast match counts as a hit
module fsp_addr_match (
  input wire logic [7:0] i_rx_byte,     // Received address byte
  input wire logic [7:0] i_slave_addr,  // Slave address
  input wire logic [7:0] i_addr_mask,   // Address enable mask
  output logic o_hit                    // Address recognised
);

  logic [7:0] bcast;

  // Masked compare and broadcast compare
  always_comb begin
    bcast = i_slave_addr | i_addr_mask;
    o_hit = (((i_rx_byte ^ i_slave_addr) & i_addr_mask) == 8'h00)
          || ((i_rx_byte & bcast) == bcast);
  end

endmodule // fsp_addr_match

// [src/fsp_baud_gen.sv]
// Purpose: Oversample tick source for one direction of the serial port
// Assumes: Timer overflow inputs are one-clock pulses
// Notes: Tick is sixteen times the bit rate in every asynchronous mode
module fsp_baud_gen import fsp_pkg::*; (
  input wire logic i_clk,              // System clock
  input wire logic i_arst_n,           // Async reset, active low
  input wire logic [1:0] i_mode,       // Operating mode
  input wire logic i_baud_double_bit,  // Fast fixed rate
  input wire logic [1:0] i_select,     // Timer source select
  input wire logic [3:0] i_timer_ovf,  // Timer rollover pulses
  output logic o_tick                  // Oversample tick
);

  typedef struct packed {
    logic [1:0] div;
    logic tick;
  } fsp_baud_s;

  fsp_baud_s q, d;
  logic [1:0] limit;

  // Fixed divider in mode 2, timer rollover pulses otherwise
  always_comb begin
    d = q;
    limit = i_baud_double_bit ? M2_TICK_FAST : M2_TICK_SLOW;
    if (i_mode == MODE_ASYNC9_FIXED) begin
      d.tick = (q.div == limit);
      d.div = (q.div == limit) ? 2'h0 : q.div + 2'h1;
    end else begin
      d.div = 2'h0;
      d.tick = i_timer_ovf[i_select];
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_tick = q.tick;

endmodule // fsp_baud_gen

// [src/fsp_pkg.sv]
// Purpose: Shared constants and types for the four mode serial port
// Assumes: 25 MHz system clock, one clock domain
// Notes: Mode code equals the mode number; mode bit 1 marks the 9-bit frames
package fsp_pkg;

  // Operating mode codes
  localparam logic [1:0] MODE_SYNC = 2'h0;
  localparam logic [1:0] MODE_ASYNC8 = 2'h1;
  localparam logic [1:0] MODE_ASYNC9_FIXED = 2'h2;
  localparam logic [1:0] MODE_ASYNC9_TIMER = 2'h3;

  // Clock and rate figures
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int OVERSAMPLE = 16;
  localparam int M2_DIV_SLOW = 64;
  localparam int M2_DIV_FAST = 32;
  localparam logic [1:0] M2_TICK_SLOW = 2'(M2_DIV_SLOW / OVERSAMPLE - 1);
  localparam logic [1:0] M2_TICK_FAST = 2'(M2_DIV_FAST / OVERSAMPLE - 1);

  // Synchronous mode bit timing, in system clocks and bit indices
  localparam logic [3:0] SYNC_BIT_LAST = 4'hB;
  localparam logic [3:0] SYNC_SAMPLE_CLK = 4'h5;
  localparam logic [3:0] SYNC_CLK_HIGH = 4'h6;
  localparam logic [3:0] SYNC_LAST_BIT = 4'h7;

  // Asynchronous bit timing, in oversample ticks and bit indices
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] RX_MID_SAMPLE = 4'h7;
  localparam logic [3:0] STOP_IDX_8 = 4'h9;
  localparam logic [3:0] STOP_IDX_9 = 4'hA;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [9:0] RESET_SHIFT = 10'h3FF;

  typedef enum logic [2:0] {
    TX_IDLE, TX_ASYNC, TX_SYNC_OUT, TX_SYNC_IN, TX_SYNC_DONE
  } fsp_tx_e;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} fsp_rx_e;

endpackage

// [src/fsp_serial_port.sv]
// Purpose: Four mode serial port: shifter, 8-bit and 9-bit UART
// Assumes: All inputs synchronous to i_clk; flag clears are one-clock pulses
// Notes: Receive pin is open drain in mode 0; pin level is resolved outside
module fsp_serial_port import fsp_pkg::*; (
  input wire logic i_clk,                 // System clock
  input wire logic i_arst_n,              // Async reset, active low
  input wire logic [1:0] i_mode_select,   // Operating mode
  input wire logic i_receive_enable_bit,  // Receive enable
  input wire logic i_address_filter_bit,  // Multiprocessor filter
  input wire logic i_transmit_ninth_bit,  // Ninth bit to send
  input wire logic i_baud_double_bit,     // Mode 2 fast rate
  input wire logic [1:0] i_tx_baud_select, // Transmit timer select
  input wire logic [1:0] i_rx_baud_select, // Receive timer select
  input wire logic [3:0] i_timer_ovf,     // Timer rollover pulses
  input wire logic [7:0] i_slave_address, // Slave address
  input wire logic [7:0] i_address_enable_mask, // Address mask
  input wire logic i_buffer_write,        // Buffer write strobe
  input wire logic [7:0] i_buffer_wdata,  // Byte to send
  input wire logic i_tx_done_clear,       // Clear transmit flag
  input wire logic i_rx_done_clear,       // Clear receive flag
  input wire logic i_collision_clear,     // Clear collision bit
  input wire logic i_interrupt_enable,    // Interrupt enable
  input wire logic i_receive_pin,         // Receive pin level
  output logic o_receive_pin_out,         // Receive pin drive value
  output logic o_receive_pin_oe,          // Receive pin drive enable
  output logic o_transmit_pin,            // Transmit pin
  output logic [7:0] o_serial_buffer,     // Received byte
  output logic o_received_ninth_bit,      // Received ninth or stop bit
  output logic o_transmit_done_flag,      // Transmit done
  output logic o_receive_done_flag,       // Receive done
  output logic o_transmit_collision_bit,  // Write during transmit
  output logic o_tx_busy,                 // Transmit engine busy
  output logic o_interrupt_req            // Interrupt request
);

  // The transmit engine also runs mode 0 reception: both use the shift clock on
  // the transmit pin, so one sequencer keeps the half-duplex order by design.
  // The receive engine serves the asynchronous modes only and stays idle in
  // mode 0, whose incoming byte borrows its shift register.

  typedef struct packed {
    fsp_tx_e tx_st;
    logic [9:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [3:0] tx_sub;
    fsp_rx_e rx_st;
    logic [9:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [3:0] rx_sub;
    logic [7:0] rbuf;
    logic rb8;
    logic ti;
    logic ri;
    logic col;
    logic tx_pin;
    logic rx_out;
    logic rx_oe;
    logic busy;
    logic irq;
  } fsp_state_s;

  // Registered state, its next value and the decoded helpers
  fsp_state_s q, d;
  logic tx_tick;
  logic rx_tick;
  logic addr_hit;
  logic sync_mode;
  logic nine_bit;
  logic [3:0] stop_idx;
  logic accept;

  // Acceptance of a finished asynchronous frame; bit8 is the ninth bit in
  // 9-bit frames and the stop bit in mode 1, where no address is checked.
  // A refused frame leaves buffer, ninth bit and flag untouched.
  function automatic logic frame_accept(input logic nine, input logic full,
    input logic filter, input logic bit8, input logic hit);
    logic ok;
    ok = 1'b0;
    if (full) begin
      ok = 1'b0;
    end else if (!filter) begin
      ok = 1'b1;
    end else if (nine) begin
      ok = bit8 && hit;
    end else begin
      ok = bit8;
    end
    return ok;
  endfunction

  // Mode decode: code equals mode number, bit 1 selects 9-bit frames
  // Only the stop position differs between the 10-bit and 11-bit frames
  assign sync_mode = (i_mode_select == MODE_SYNC);
  assign nine_bit = i_mode_select[1];
  assign stop_idx = nine_bit ? STOP_IDX_9 : STOP_IDX_8;

  // Independent baud sources for each direction
  // Each keeps its own divider, so every bit cell but the transmit start bit starts on its own direction's tick
  fsp_baud_gen u_tx_baud (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_mode(i_mode_select),
    .i_baud_double_bit(i_baud_double_bit),
    .i_select(i_tx_baud_select),
    .i_timer_ovf(i_timer_ovf),
    .o_tick(tx_tick)
  );

  fsp_baud_gen u_rx_baud (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_mode(i_mode_select),
    .i_baud_double_bit(i_baud_double_bit),
    .i_select(i_rx_baud_select),
    .i_timer_ovf(i_timer_ovf),
    .o_tick(rx_tick)
  );

  // Address check on the eight data bits already captured
  // The compare is ready before the last sample, so acceptance needs no extra cycle
  fsp_addr_match u_addr (
    .i_rx_byte(q.rx_sh[7:0]),
    .i_slave_addr(i_slave_address),
    .i_addr_mask(i_address_enable_mask),
    .o_hit(addr_hit)
  );

  // Next-state logic for both engines, flags and pins
  always_comb begin
    d = q;
    accept = 1'b0;

    // Software clears first, so a same-cycle hardware set wins
    // and a set that lands on a clear pulse is kept, though a frame ending on it still sees the old receive flag
    if (i_tx_done_clear) begin
      d.ti = 1'b0;
    end
    if (i_rx_done_clear) begin
      d.ri = 1'b0;
    end
    if (i_collision_clear) begin
      d.col = 1'b0;
    end

    // Buffer write: start a frame, or flag a collision when busy
    if (i_buffer_write) begin
      if (q.tx_st != TX_IDLE) begin
        d.col = 1'b1;
      end else if (sync_mode) begin
        d.tx_st = TX_SYNC_OUT;
        d.tx_sh = {2'b11, i_buffer_wdata};
        d.tx_cnt = 4'h0;
        d.tx_sub = 4'h0;
      end else begin
        d.tx_st = TX_ASYNC;
        d.tx_sh = {1'b1, (nine_bit ? i_transmit_ninth_bit : 1'b1), i_buffer_wdata};
        d.tx_cnt = 4'h0;
        d.tx_sub = 4'h0;
      end
    end

    // Transmit engine, which also runs mode 0 reception
    unique case (q.tx_st)
      TX_IDLE: begin
        if (!i_buffer_write && sync_mode && i_receive_enable_bit && !q.ri) begin
          d.tx_st = TX_SYNC_IN;
          d.tx_cnt = 4'h0;
          d.tx_sub = 4'h0;
        end
      end
      TX_ASYNC: begin
        // The start bit runs from the write to the sixteenth tick, so it may
        // be up to one tick shorter than a nominal bit cell
        if (tx_tick) begin
          d.tx_sub = q.tx_sub + 4'h1;
          if (q.tx_sub == OVERSAMPLE_LAST) begin
            if (q.tx_cnt == stop_idx) begin
              d.tx_st = TX_IDLE;
            end else begin
              d.tx_cnt = q.tx_cnt + 4'h1;
              if ((q.tx_cnt + 4'h1) == stop_idx) begin
                d.ti = 1'b1;
              end
            end
          end
        end
      end
      TX_SYNC_OUT, TX_SYNC_IN: begin
        // Twelve system clocks per bit
        // Clock low for six, high for six; data held for the whole bit
        d.tx_sub = (q.tx_sub == SYNC_BIT_LAST) ? 4'h0 : q.tx_sub + 4'h1;
        if (q.tx_st == TX_SYNC_IN && q.tx_sub == SYNC_SAMPLE_CLK) begin
          d.rx_sh[q.tx_cnt] = i_receive_pin;
        end
        if (q.tx_sub == SYNC_BIT_LAST) begin
          if (q.tx_cnt == SYNC_LAST_BIT) begin
            if (q.tx_st == TX_SYNC_OUT) begin
              d.tx_st = TX_IDLE;
              d.ti = 1'b1;
            end else begin
              d.tx_st = TX_SYNC_DONE;
            end
          end else begin
            d.tx_cnt = q.tx_cnt + 4'h1;
          end
        end
      end
      TX_SYNC_DONE: begin
        // One cycle after the last bit: deliver byte and halt reception
        d.tx_st = TX_IDLE;
        d.rbuf = q.rx_sh[7:0];
        d.ri = 1'b1;
      end
      default: begin
        d.tx_st = TX_IDLE;
      end
    endcase

    // Asynchronous receive engine, sixteen ticks per bit
    unique case (q.rx_st)
      RX_IDLE: begin
        if (!sync_mode && i_receive_enable_bit && rx_tick && !i_receive_pin) begin
          d.rx_st = RX_START;
          d.rx_sub = 4'h0;
        end
      end
      RX_START: begin
        // Mid-bit check eight ticks after the falling edge was seen
        if (rx_tick && !sync_mode) begin
          d.rx_sub = q.rx_sub + 4'h1;
          if (q.rx_sub == RX_MID_SAMPLE) begin
            // A start bit gone high by mid-bit was a glitch
            if (i_receive_pin) begin
              d.rx_st = RX_IDLE;
            end else begin
              d.rx_st = RX_DATA;
              d.rx_sub = 4'h0;
              d.rx_cnt = 4'h0;
            end
          end
        end
      end
      RX_DATA: begin
        if (rx_tick && !sync_mode) begin
          d.rx_sub = q.rx_sub + 4'h1;
          if (q.rx_sub == OVERSAMPLE_LAST) begin
            d.rx_sh[q.rx_cnt] = i_receive_pin;
            if (q.rx_cnt == stop_idx - 4'h1) begin
              d.rx_st = RX_IDLE;
              // In 9-bit frames the stop bit is ignored; ninth bit and address
              // decide. In mode 1 bit 8 holds the stop bit.
              accept = frame_accept(nine_bit, q.ri, i_address_filter_bit, d.rx_sh[8],
                addr_hit);
              if (accept) begin
                d.rbuf = d.rx_sh[7:0];
                d.rb8 = d.rx_sh[8];
                d.ri = 1'b1;
              end
            end else begin
              d.rx_cnt = q.rx_cnt + 4'h1;
            end
          end
        end
      end
      default: begin
        d.rx_st = RX_IDLE;
      end
    endcase

    // Shift mode borrows the receive shift register: drop any frame in flight
    if (sync_mode && q.rx_st != RX_IDLE) begin
      d.rx_st = RX_IDLE;
    end

    // Transmit pin: frame bits in async modes, shift clock in mode 0
    unique case (d.tx_st)
      TX_ASYNC: begin
        d.tx_pin = (d.tx_cnt == 4'h0) ? 1'b0 : d.tx_sh[d.tx_cnt - 4'h1];
      end
      TX_SYNC_OUT, TX_SYNC_IN: begin
        d.tx_pin = (d.tx_sub >= SYNC_CLK_HIGH);
      end
      default: begin
        d.tx_pin = 1'b1;
      end
    endcase

    // Receive pin: open drain, pulled low only for a zero data bit
    // The pull-up supplies the ones, so only the enable ever moves
    d.rx_out = 1'b0;
    d.rx_oe = (d.tx_st == TX_SYNC_OUT) && !d.tx_sh[d.tx_cnt];
    d.busy = (d.tx_st != TX_IDLE);
    d.irq = i_interrupt_enable && (d.ti || d.ri);
  end

  // State register; reset leaves the transmit pin at the idle level and
  // both engines idle, so no false edge reaches the far side
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
      q.tx_st <= TX_IDLE;
      q.rx_st <= RX_IDLE;
      q.tx_sh <= RESET_SHIFT;
      q.rbuf <= RESET_BYTE;
      q.tx_pin <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  // so no pin can glitch on a decode
  assign o_receive_pin_out = q.rx_out;
  assign o_receive_pin_oe = q.rx_oe;
  assign o_transmit_pin = q.tx_pin;
  assign o_serial_buffer = q.rbuf;
  assign o_received_ninth_bit = q.rb8;
  assign o_transmit_done_flag = q.ti;
  assign o_receive_done_flag = q.ri;
  assign o_transmit_collision_bit = q.col;
  assign o_tx_busy = q.busy;
  assign o_interrupt_req = q.irq;

endmodule // fsp_serial_port

// [verif/fsp_peer.sv]
// Purpose: Remote UART node and external shift register on the far side
// Assumes: Receive line has a pull-up; o_drive at 1 releases it
// Notes: Tasks are called by the bench; shifting out runs only with shift_en, capture always runs
module fsp_peer (
  input wire logic i_clk, // System clock
  input wire logic i_sclk, // Transmit pin, shift clock in mode 0
  input wire logic i_line, // Resolved receive line
  output logic o_drive // Line drive, 1 releases
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] shreg;
  logic [7:0] cap;
  logic shift_en;
  initial begin
    o_drive = 1'b1;
    shift_en = 1'b0;
  end
  // Next bit out after the shift clock falls, ones refill behind
  always @(negedge i_sclk) begin
    if (shift_en) begin
      o_drive <= shreg[0];
      shreg <= {1'b1, shreg[7:1]};
    end
  end
  // Capture on the rising shift clock, first bit ends in bit 0
  always @(posedge i_sclk) cap <= {i_line, cap[7:1]};
  // Send a frame LSB first; a low stop bit is cut short to avoid a false start
  task automatic send(input logic [10:0] bits, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      o_drive = bits[i];
      repeat ((i == n - 1 && !bits[i]) ? per * 5 / 8 : per) @(posedge i_clk);
      #1;
    end
    o_drive = 1'b1;
    repeat (per) @(posedge i_clk);
    #1;
  endtask
  // Sample a frame from the transmit pin in mid-bit
  task automatic catch_frame(input int n, input int per, output logic [10:0] bits);
    int k;
    k = 0;
    bits = '1;
    while (i_sclk && k < 4000) begin
      @(posedge i_clk);
      k++;
    end
    repeat (per / 2) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = i_sclk;
      if (i < n - 1) repeat (per) @(posedge i_clk);
    end
  endtask
endmodule // fsp_peer

// [verif/fsp_serial_port_checker.sv]
// Purpose: Port-level assertions for the four mode serial port
// Assumes: One clock domain, async active-low reset
// Notes: Bound to the top module after the checker
module fsp_serial_port_checker import fsp_pkg::*; (
  input wire logic i_clk, // Clock
  input wire logic i_arst_n, // Reset
  input wire logic [1:0] i_mode_select, // Mode
  input wire logic i_buffer_write, // Write strobe
  input wire logic i_tx_done_clear, // Transmit clear
  input wire logic i_rx_done_clear, // Receive clear
  input wire logic i_interrupt_enable, // Interrupt enable
  input wire logic o_receive_pin_out, // Pin value
  input wire logic o_receive_pin_oe, // Pin enable
  input wire logic o_transmit_pin, // Transmit pin
  input wire logic [7:0] o_serial_buffer, // Received byte
  input wire logic o_transmit_done_flag, // Transmit done
  input wire logic o_receive_done_flag, // Receive done
  input wire logic o_transmit_collision_bit, // Collision
  input wire logic o_tx_busy, // Busy
  input wire logic o_interrupt_req // Interrupt
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // Launch, collision and idle level of the transmitter
  tx_start_a: assert property (
    i_buffer_write && !o_tx_busy && i_mode_select != MODE_SYNC |=> o_tx_busy && !o_transmit_pin)
    else $error("no start bit after write");
  tx_collide_a: assert property (i_buffer_write && o_tx_busy |=> o_transmit_collision_bit)
    else $error("collision not flagged");
  idle_high_a: assert property (!o_tx_busy |-> o_transmit_pin)
    else $error("transmit pin low while idle");
  tx_done_when_a: assert property (
    $rose(o_transmit_done_flag) |-> o_transmit_pin && (o_tx_busy == (i_mode_select != MODE_SYNC)))
    else $error("transmit done at wrong time");
  // Flags hold until cleared; received byte frozen while flagged
  tx_flag_hold_a: assert property (o_transmit_done_flag && !i_tx_done_clear |=> o_transmit_done_flag)
    else $error("transmit flag dropped");
  rx_flag_hold_a: assert property (
    o_receive_done_flag && !i_rx_done_clear |=> o_receive_done_flag && $stable(o_serial_buffer))
    else $error("receive flag or byte changed");
  irq_level_a: assert property (
    o_interrupt_req == ($past(i_interrupt_enable) && (o_transmit_done_flag || o_receive_done_flag)))
    else $error("interrupt request wrong");
  // Shift mode pin behaviour
  sync_clock_a: assert property (
    $fell(o_transmit_pin) && i_mode_select == MODE_SYNC |-> !o_transmit_pin [*6] ##1 o_transmit_pin)
    else $error("shift clock low phase wrong");
  open_drain_a: assert property (
    !o_receive_pin_out && (!o_receive_pin_oe || (o_tx_busy && i_mode_select == MODE_SYNC)))
    else $error("receive pin driven wrongly");
endmodule // fsp_serial_port_checker

bind fsp_serial_port fsp_serial_port_checker fsp_serial_port_checker_inst (.i_clk, .i_arst_n,
  .i_mode_select, .i_buffer_write, .i_tx_done_clear, .i_rx_done_clear, .i_interrupt_enable,
  .o_receive_pin_out, .o_receive_pin_oe, .o_transmit_pin, .o_serial_buffer,
  .o_transmit_done_flag, .o_receive_done_flag, .o_transmit_collision_bit, .o_tx_busy,
  .o_interrupt_req);

// [verif/test_fsp_serial_port.sv]
// Purpose: Self-checking bench for the four mode serial port
// Assumes: 25 MHz clock; inputs change 1 ns after the rising edge
// Notes: Timer k rolls over every k+2 clocks, so each select gives its own rate
module test_fsp_serial_port import fsp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [1:0] i_mode_select = 2'h1, i_tx_baud_select = 2'h0, i_rx_baud_select = 2'h0;
  logic i_receive_enable_bit = 1'b0, i_address_filter_bit = 1'b0, i_transmit_ninth_bit = 1'b0;
  logic i_baud_double_bit = 1'b0, i_buffer_write = 1'b0, i_interrupt_enable = 1'b0;
  logic i_tx_done_clear = 1'b0, i_rx_done_clear = 1'b0, i_collision_clear = 1'b0;
  logic [3:0] i_timer_ovf = 4'h0;
  logic [7:0] i_slave_address = 8'h00, i_address_enable_mask = 8'h00, i_buffer_wdata = 8'h00;
  logic i_receive_pin, o_receive_pin_out, o_receive_pin_oe, o_transmit_pin, peer_drive;
  logic [7:0] o_serial_buffer;
  logic o_received_ninth_bit, o_transmit_done_flag, o_receive_done_flag;
  logic o_transmit_collision_bit, o_tx_busy, o_interrupt_req;
  int num_errors = 0, checked = 0, cycles = 0;

  always #20 i_clk = ~i_clk;
  // Open-drain receive line with pull-up
  assign i_receive_pin = o_receive_pin_oe ? 1'b0 : peer_drive;
  fsp_serial_port fsp_serial_port_inst (.i_clk, .i_arst_n, .i_mode_select, .i_receive_enable_bit,
    .i_address_filter_bit, .i_transmit_ninth_bit, .i_baud_double_bit, .i_tx_baud_select,
    .i_rx_baud_select, .i_timer_ovf, .i_slave_address, .i_address_enable_mask, .i_buffer_write,
    .i_buffer_wdata, .i_tx_done_clear, .i_rx_done_clear, .i_collision_clear, .i_interrupt_enable,
    .i_receive_pin, .o_receive_pin_out, .o_receive_pin_oe, .o_transmit_pin, .o_serial_buffer,
    .o_received_ninth_bit, .o_transmit_done_flag, .o_receive_done_flag,
    .o_transmit_collision_bit, .o_tx_busy, .o_interrupt_req);
  fsp_peer fsp_peer_inst (.i_clk, .i_sclk(o_transmit_pin), .i_line(i_receive_pin),
    .o_drive(peer_drive));

  // Timer rollover pulses and the run-length guard
  always @(posedge i_clk) begin
    #1;
    cycles++;
    for (int k = 0; k < 4; k++) i_timer_ovf[k] = (cycles % (k + 2)) == 0;
    if (cycles == 40000) begin
      num_errors++;
      end_of_test();
    end
  end

  // Clocks per bit for the selected source
  function automatic int bit_clks(logic [1:0] m, logic [1:0] sel, logic dbl);
    return (m == MODE_ASYNC9_FIXED) ? (dbl ? 32 : 64) : 16 * (int'(sel) + 2);
  endfunction
  // Frame bits from bit 0 up: start, data, ninth or stop
  function automatic logic [10:0] frame(logic [1:0] m, logic [7:0] b, logic nb, logic sb);
    return (m == MODE_ASYNC8) ? {1'b1, sb, b, 1'b0} : {sb, nb, b, 1'b0};
  endfunction
  // Acceptance of a received frame
  function automatic logic accept(logic [1:0] m, logic ri, logic f, logic nb, logic sb,
    logic [7:0] b);
    logic [7:0] bc;
    bc = i_slave_address | i_address_enable_mask;
    if (ri) return 1'b0;
    if (m == MODE_ASYNC8) return !f || sb;
    return !f || (nb && ((((b ^ i_slave_address) & i_address_enable_mask) == 8'h00)
      || ((b & bc) == bc)));
  endfunction

  task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic pulse_clears();
    {i_tx_done_clear, i_rx_done_clear, i_collision_clear} = 3'h7;
    cyc(1);
    {i_tx_done_clear, i_rx_done_clear, i_collision_clear} = 3'h0;
  endtask
  task automatic write_byte(input logic [7:0] b);
    i_buffer_wdata = b;
    i_buffer_write = 1'b1;
    cyc(1);
    i_buffer_write = 1'b0;
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 3000 && o_tx_busy !== 1'b0; k++) cyc(1);
  endtask

  // Main sequence
  initial begin
    logic [10:0] got;
    logic [7:0] b, exp_buf;
    logic nb, sb, ok, exp_ri, exp_nb;
    exp_buf = 8'h00;
    exp_ri = 1'b0;
    exp_nb = 1'b0;
    void'($urandom(32'h187c1c49));
    cyc(4);
    i_arst_n = 1'b1;
    cyc(2);
    // Transmit in each asynchronous mode, with a write while busy
    for (int i = 0; i < 6; i++) begin
      i_mode_select = 2'(1 + i % 3);
      i_tx_baud_select = 2'($urandom);
      i_baud_double_bit = 1'($urandom);
      i_transmit_ninth_bit = 1'($urandom);
      i_interrupt_enable = 1'($urandom);
      b = (i < 2) ? {8{i[0]}} : 8'($urandom);
      fork
        fsp_peer_inst.catch_frame((i_mode_select == MODE_ASYNC8) ? 10 : 11,
          bit_clks(i_mode_select, i_tx_baud_select, i_baud_double_bit), got);
        begin
          write_byte(b);
          cyc(3);
          write_byte(~b);
        end
      join
      chk("tx frame", got, frame(i_mode_select, b, i_transmit_ninth_bit, 1'b1));
      wait_idle();
      chk("tx flags",
        11'({o_transmit_done_flag, o_transmit_collision_bit, o_interrupt_req}),
        11'({2'h3, i_interrupt_enable}));
      pulse_clears();
    end
    // Receive in each asynchronous mode: filter, address, full-flag cases
    i_receive_enable_bit = 1'b1;
    i_interrupt_enable = 1'b1;
    for (int i = 0; i < 12; i++) begin
      i_mode_select = 2'(1 + i % 3);
      i_rx_baud_select = 2'($urandom);
      i_tx_baud_select = ~i_rx_baud_select;
      i_baud_double_bit = 1'($urandom);
      i_address_filter_bit = 1'($urandom);
      i_slave_address = 8'($urandom);
      i_address_enable_mask = 8'($urandom);
      nb = (i % 4 != 3); // Address bytes carry a one, data bytes a zero
      sb = (i_mode_select == MODE_ASYNC8) ? 1'($urandom) : 1'b1;
      b = (i % 4 == 0) ? i_slave_address ^ ~i_address_enable_mask
        : (i % 4 == 1) ? 8'hFF : 8'($urandom);
      if (1'($urandom)) begin
        i_rx_done_clear = 1'b1;
        cyc(1);
        i_rx_done_clear = 1'b0;
        exp_ri = 1'b0;
      end
      ok = accept(i_mode_select, exp_ri, i_address_filter_bit, nb, sb, b);
      fsp_peer_inst.send(frame(i_mode_select, b, nb, sb), (i_mode_select == MODE_ASYNC8) ? 10 : 11,
        bit_clks(i_mode_select, i_rx_baud_select, i_baud_double_bit));
      if (ok) begin
        exp_buf = b;
        exp_nb = (i_mode_select == MODE_ASYNC8) ? sb : nb;
        exp_ri = 1'b1;
      end
      chk("rx state",
        11'({o_interrupt_req, o_receive_done_flag, o_received_ninth_bit, o_serial_buffer}),
        11'({exp_ri, exp_ri, exp_nb, exp_buf}));
    end
    // Shift mode: send one byte, then take one in
    i_receive_enable_bit = 1'b0;
    i_mode_select = MODE_SYNC;
    pulse_clears();
    b = 8'($urandom);
    write_byte(b);
    wait_idle();
    chk("sync tx", 11'({o_transmit_done_flag, fsp_peer_inst.cap}), 11'({1'b1, b}));
    b = 8'($urandom);
    fsp_peer_inst.shreg = b;
    fsp_peer_inst.shift_en = 1'b1;
    pulse_clears();
    i_receive_enable_bit = 1'b1;
    cyc(2);
    wait_idle();
    fsp_peer_inst.shift_en = 1'b0;
    fsp_peer_inst.o_drive = 1'b1;
    chk("sync rx", 11'({o_receive_done_flag, o_serial_buffer}), 11'({1'b1, b}));
    end_of_test();
  end
endmodule // test_fsp_serial_port
